// [rtl/fgp_port.sv]
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module fgp_port #(
    parameter int NPORTS = fgp_pkg::FGP_NPORTS,
    parameter int PW     = fgp_pkg::FGP_DATA_W
) (
    // Clock and reset.
    input  wire logic                               aclk,
    input  wire logic                               aresetn,
    // AXI4-Lite slave.
    input  wire logic [fgp_pkg::FGP_ADDR_W-1:0]     s_axi_awaddr,
    input  wire logic                               s_axi_awvalid,
    output logic                                    s_axi_awready,
    input  wire logic [31:0]                        s_axi_wdata,
    input  wire logic [3:0]                         s_axi_wstrb,
    input  wire logic                               s_axi_wvalid,
    output logic                                    s_axi_wready,
    output logic [1:0]                              s_axi_bresp,
    output logic                                    s_axi_bvalid,
    input  wire logic                               s_axi_bready,
    input  wire logic [fgp_pkg::FGP_ADDR_W-1:0]     s_axi_araddr,
    input  wire logic                               s_axi_arvalid,
    output logic                                    s_axi_arready,
    output logic [31:0]                             s_axi_rdata,
    output logic [1:0]                              s_axi_rresp,
    output logic                                    s_axi_rvalid,
    input  wire logic                               s_axi_rready,
    // Dedicated peripheral functions.
    input  wire logic [NPORTS-1:0][PW-1:0]          periph_sel,
    input  wire logic [NPORTS-1:0][PW-1:0]          periph_out,
    input  wire logic [NPORTS-1:0][PW-1:0]          periph_oe,
    // Pins.
    input  wire logic [NPORTS-1:0][PW-1:0]          pin_in,
    output logic [NPORTS-1:0][PW-1:0]               pin_out,
    output logic [NPORTS-1:0][PW-1:0]               pin_oe,
    // Interrupts and wake-up.
    input  wire logic                               ext_irq_in,
    output logic                                    irq,
    output logic                                    shared_external_irq_line,
    output logic                                    wake_req
);
    import fgp_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    logic [NPORTS-1:0][PW-1:0] dir_reg, out_reg, mask_reg, rise_reg, fall_reg, estat_reg;
    logic [NPORTS-1:0][PW-1:0] sync1_reg, sync2_reg, prev_reg, edge_new;
    logic [NPORTS-1:0]         ist_reg, imsk_reg, any_edge;
    logic [NPORTS-1:0]         wake_p;
    fgp_wreq_t                 wq_reg;
    logic                      aw_full_reg, w_full_reg, do_wr, do_rd;
    fgp_dec_t                  wd, rd;
    logic [31:0]               bm, rdata_next;

    function automatic fgp_dec_t decode(input logic [8:0] a);
        fgp_dec_t d;
        d = '{ok: 1'b0, port: 1'b0, legacy: 1'b0, fn: FGP_F_DIR};
        if (a < FGP_PORT_BASE + 9'(NPORTS) * FGP_PORT_STRIDE) begin
            d.port = a[5];
            d.ok   = 1'b1;
            unique case (a[4:0])
                FGP_OFF_DIR:  d.fn = FGP_F_DIR;
                FGP_OFF_MASK: d.fn = FGP_F_MASK;
                FGP_OFF_PIN:  d.fn = FGP_F_PIN;
                FGP_OFF_SET:  d.fn = FGP_F_SET;
                FGP_OFF_CLR:  d.fn = FGP_F_CLR;
                FGP_OFF_OUT:  d.fn = FGP_F_OUT;
                default:      d.ok = 1'b0;
            endcase
        end else if (a >= FGP_EDGE_BASE && a < FGP_EDGE_BASE + 9'h020) begin
            d.port = a[4];
            d.ok   = 1'b1;
            unique case (a[3:0])
                FGP_OFF_RISE:  d.fn = FGP_F_RISE;
                FGP_OFF_FALL:  d.fn = FGP_F_FALL;
                FGP_OFF_ESTAT: d.fn = FGP_F_ESTAT;
                FGP_OFF_ECLR:  d.fn = FGP_F_ECLR;
                default:       d.ok = 1'b0;
            endcase
        end else if (a == FGP_ADDR_IST) begin
            d.ok = 1'b1;
            d.fn = FGP_F_IST;
        end else if (a == FGP_ADDR_IMSK) begin
            d.ok = 1'b1;
            d.fn = FGP_F_IMSK;
        end else if (a >= FGP_LEG_BASE && a < FGP_LEG_BASE + 9'h020) begin
            // The older set has no mask; it reaches the same latches directly.
            d.port   = a[4];
            d.legacy = 1'b1;
            d.ok     = 1'b1;
            unique case (a[3:0])
                FGP_LEG_PIN: d.fn = FGP_F_PIN;
                FGP_LEG_SET: d.fn = FGP_F_SET;
                FGP_LEG_DIR: d.fn = FGP_F_DIR;
                FGP_LEG_CLR: d.fn = FGP_F_CLR;
                default:     d.ok = 1'b0;
            endcase
        end
        return d;
    endfunction : decode

    ////////////////////////////////////////////////////////////////////////////////
    // Address and data are held apart so either may arrive first.
    assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
    assign do_wr         = aw_full_reg && w_full_reg && !s_axi_bvalid;
    assign wd            = decode(wq_reg.addr);
    assign bm            = {{8{wq_reg.strb[3]}}, {8{wq_reg.strb[2]}},
                            {8{wq_reg.strb[1]}}, {8{wq_reg.strb[0]}}};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg  <= 1'b0;
            w_full_reg   <= 1'b0;
            wq_reg       <= '0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FGP_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_reg <= 1'b1;
                wq_reg.addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_reg  <= 1'b1;
                wq_reg.data <= s_axi_wdata;
                wq_reg.strb <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_full_reg  <= 1'b0;
                w_full_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wd.ok ? FGP_RESP_OKAY : FGP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign do_rd         = s_axi_arvalid && s_axi_arready;
    assign rd            = decode(s_axi_araddr);

    always_comb begin
        rdata_next = FGP_RST_ZERO;
        unique case (rd.fn)
            FGP_F_DIR:   rdata_next = dir_reg[rd.port];
            FGP_F_MASK:  rdata_next = mask_reg[rd.port];
            FGP_F_PIN:   rdata_next = rd.legacy ? sync2_reg[rd.port]
                                    : sync2_reg[rd.port] & ~mask_reg[rd.port];
            FGP_F_SET,
            FGP_F_OUT:   rdata_next = out_reg[rd.port];
            FGP_F_CLR,
            FGP_F_ECLR:  rdata_next = FGP_RST_ZERO;
            FGP_F_RISE:  rdata_next = rise_reg[rd.port];
            FGP_F_FALL:  rdata_next = fall_reg[rd.port];
            FGP_F_ESTAT: rdata_next = estat_reg[rd.port];
            FGP_F_IST:   rdata_next = 32'(ist_reg);
            FGP_F_IMSK:  rdata_next = 32'(imsk_reg);
        endcase
        if (!rd.ok) begin
            rdata_next = FGP_RST_ZERO;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= FGP_RST_ZERO;
            s_axi_rresp  <= FGP_RESP_OKAY;
        end else if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdata_next;
            s_axi_rresp  <= rd.ok ? FGP_RESP_OKAY : FGP_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    for (genvar p = 0; p < NPORTS; p++) begin : g_port
        logic wr;
        logic [PW-1:0] wmask;
        assign wr    = do_wr && wd.ok && (wd.port == 1'(p));
        assign wmask = wd.legacy ? bm : bm & ~mask_reg[p];

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dir_reg[p] <= FGP_RST_ZERO;
            end else if (wr && wd.fn == FGP_F_DIR) begin
                dir_reg[p] <= (dir_reg[p] & ~bm) | (wq_reg.data & bm);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                out_reg[p] <= FGP_RST_ZERO;
            end else if (wr && wd.fn == FGP_F_PIN) begin
                out_reg[p] <= (out_reg[p] & ~wmask) | (wq_reg.data & wmask);
            end else if (wr && wd.fn == FGP_F_SET) begin
                out_reg[p] <= out_reg[p] | (wq_reg.data & wmask);
            end else if (wr && wd.fn == FGP_F_CLR) begin
                out_reg[p] <= out_reg[p] & ~(wq_reg.data & wmask);
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                mask_reg[p] <= FGP_RST_ZERO;
                rise_reg[p] <= FGP_RST_ZERO;
                fall_reg[p] <= FGP_RST_ZERO;
            end else if (wr && wd.fn == FGP_F_MASK) begin
                mask_reg[p] <= (mask_reg[p] & ~bm) | (wq_reg.data & bm);
            end else if (wr && wd.fn == FGP_F_RISE) begin
                rise_reg[p] <= (rise_reg[p] & ~bm) | (wq_reg.data & bm);
            end else if (wr && wd.fn == FGP_F_FALL) begin
                fall_reg[p] <= (fall_reg[p] & ~bm) | (wq_reg.data & bm);
            end
        end

        // Only the second stage feeds edge logic; the first may be metastable.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                sync1_reg[p] <= FGP_RST_ZERO;
                sync2_reg[p] <= FGP_RST_ZERO;
                prev_reg[p]  <= FGP_RST_ZERO;
            end else begin
                sync1_reg[p] <= pin_in[p];
                sync2_reg[p] <= sync1_reg[p];
                prev_reg[p]  <= sync2_reg[p];
            end
        end

        assign edge_new[p] = (sync2_reg[p] & ~prev_reg[p] & rise_reg[p])
                           | (~sync2_reg[p] & prev_reg[p] & fall_reg[p]);
        assign any_edge[p] = |edge_new[p];

        // A new edge in the clearing cycle survives the clear.
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                estat_reg[p] <= FGP_RST_ZERO;
            end else begin
                estat_reg[p] <= (estat_reg[p]
                    & ~((wr && wd.fn == FGP_F_ECLR) ? wq_reg.data & bm : FGP_RST_ZERO))
                    | edge_new[p];
            end
        end

        // The pin is compared with the last clocked level, so an enabled edge
        // raises wake-up even with the clock stopped.
        assign wake_p[p] = |((pin_in[p] & ~prev_reg[p] & rise_reg[p])
                           | (~pin_in[p] & prev_reg[p] & fall_reg[p]));

        assign pin_out[p] = (periph_sel[p] & periph_out[p]) | (~periph_sel[p] & out_reg[p]);
        assign pin_oe[p]  = (periph_sel[p] & periph_oe[p]) | (~periph_sel[p] & dir_reg[p]);
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ist_reg  <= '0;
            imsk_reg <= '0;
        end else begin
            ist_reg <= ((do_rd && rd.ok && rd.fn == FGP_F_IST) ? '0 : ist_reg) | any_edge;
            if (do_wr && wd.ok && wd.fn == FGP_F_IMSK && wq_reg.strb[0]) begin
                imsk_reg <= wq_reg.data[NPORTS-1:0];
            end
        end
    end

    assign irq                      = |(ist_reg & imsk_reg);
    assign shared_external_irq_line = irq | ext_irq_in;
    assign wake_req                 = |(wake_p & imsk_reg) | irq;

    ////////////////////////////////////////////////////////////////////////////////
    logic wr_p0;
    assign wr_p0 = do_wr && wd.ok && !wd.port && !wd.legacy;

    property p_dir_reset;
        @(posedge aclk) !aresetn |=> dir_reg[0] == FGP_RST_ZERO
                                     && pin_oe[0] == (periph_oe[0] & periph_sel[0]);
    endproperty
    a_dir_reset: assert property (p_dir_reset) else $error("Direction not input after reset.");

    property p_dir_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_DIR && wq_reg.strb == 4'hF |=> dir_reg[0] == $past(wq_reg.data);
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("Direction write lost.");

    property p_set_only;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_SET && wq_reg.strb == 4'hF && mask_reg[0] == FGP_RST_ZERO
        |=> out_reg[0] == ($past(out_reg[0]) | $past(wq_reg.data));
    endproperty
    a_set_only: assert property (p_set_only) else $error("Set write changed wrong bits.");

    property p_clr_only;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_CLR && wq_reg.strb == 4'hF && mask_reg[0] == FGP_RST_ZERO
        |=> out_reg[0] == ($past(out_reg[0]) & ~$past(wq_reg.data));
    endproperty
    a_clr_only: assert property (p_clr_only) else $error("Clear write changed wrong bits.");

    property p_mask_keep;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_PIN |=> (out_reg[0] & $past(mask_reg[0]))
                                         == ($past(out_reg[0]) & $past(mask_reg[0]));
    endproperty
    a_mask_keep: assert property (p_mask_keep) else $error("Masked latch bit changed.");

    property p_lane_keep;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_DIR && !wq_reg.strb[0] |=> dir_reg[0][7:0] == $past(dir_reg[0][7:0]);
    endproperty
    a_lane_keep: assert property (p_lane_keep) else $error("Unstrobed byte changed.");

    property p_full_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_p0 && wd.fn == FGP_F_PIN && wq_reg.strb == 4'hF && mask_reg[0] == FGP_RST_ZERO
        |=> ##1 (pin_out[0] & ~periph_sel[0]) == ($past(wq_reg.data, 2) & ~periph_sel[0]);
    endproperty
    a_full_write: assert property (p_full_write) else $error("Full write did not reach pins.");

    property p_rise_catch;
        @(posedge aclk) disable iff (!aresetn)
        rise_reg[0][0] && $rose(sync2_reg[0][0]) |=> estat_reg[0][0] ##0 ist_reg[0];
    endproperty
    a_rise_catch: assert property (p_rise_catch) else $error("Rising edge not captured.");

    property p_pending_hold;
        @(posedge aclk) disable iff (!aresetn)
        estat_reg[0][0] && !(wr_p0 && wd.fn == FGP_F_ECLR) |=> estat_reg[0][0];
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("Edge dropped early.");

    property p_shared_line;
        @(posedge aclk) disable iff (!aresetn)
        |(ist_reg & imsk_reg) |-> shared_external_irq_line && wake_req;
    endproperty
    a_shared_line: assert property (p_shared_line) else $error("Edge irq not on shared line.");

    property p_periph_pin;
        @(posedge aclk) disable iff (!aresetn)
        periph_sel[0][0] |-> pin_out[0][0] == periph_out[0][0] && pin_oe[0][0] == periph_oe[0][0];
    endproperty
    a_periph_pin: assert property (p_periph_pin) else $error("Peripheral pin not passed.");

    c_set_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_p0 && wd.fn == FGP_F_SET);
    c_edge_irq:  cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
    c_legacy_wr: cover property (@(posedge aclk) disable iff (!aresetn) do_wr && wd.legacy);

endmodule : fgp_port

// [pkg/fgp_pkg.sv]
// Behaviour
// - Unassigned pins driven and sampled by port registers.
// - Each pin has its own direction bit.
// - Set and clear writes change only one-bits.
// - Output latch and live pin level readable.
// - Mask excludes chosen bits from writes and reads.
// - Byte and half-word accesses touch only addressed bits.
// - One full-width write updates every port pin.
// - Per-pin rising, falling or both-edge interrupt.
// - Edge detection works while the clock stops.
// - Enabled edge interrupts wake the chip.
// - All pins not given to a peripheral are inputs after reset.
// - Older register set for first two ports.
// - Edge interrupts ORed into shared external line.
package fgp_pkg;

    localparam int          FGP_ADDR_W     = 9;
    localparam int          FGP_DATA_W     = 32;
    localparam int          FGP_NPORTS     = 2;

    // Port p main block sits at FGP_PORT_BASE + p * FGP_PORT_STRIDE.
    localparam logic [8:0]  FGP_PORT_BASE  = 9'h000;
    localparam logic [8:0]  FGP_PORT_STRIDE = 9'h020;
    localparam logic [4:0]  FGP_OFF_DIR    = 5'h00;
    localparam logic [4:0]  FGP_OFF_MASK   = 5'h04;
    localparam logic [4:0]  FGP_OFF_PIN    = 5'h08;
    localparam logic [4:0]  FGP_OFF_SET    = 5'h0C;
    localparam logic [4:0]  FGP_OFF_CLR    = 5'h10;
    localparam logic [4:0]  FGP_OFF_OUT    = 5'h14;

    // Edge block of port p at FGP_EDGE_BASE + p * 0x10.
    localparam logic [8:0]  FGP_EDGE_BASE  = 9'h080;
    localparam logic [3:0]  FGP_OFF_RISE   = 4'h0;
    localparam logic [3:0]  FGP_OFF_FALL   = 4'h4;
    localparam logic [3:0]  FGP_OFF_ESTAT  = 4'h8;
    localparam logic [3:0]  FGP_OFF_ECLR   = 4'hC;

    localparam logic [8:0]  FGP_ADDR_IST   = 9'h0C0;
    localparam logic [8:0]  FGP_ADDR_IMSK  = 9'h0C4;

    // Older register set of port p at FGP_LEG_BASE + p * 0x10.
    localparam logic [8:0]  FGP_LEG_BASE   = 9'h100;
    localparam logic [3:0]  FGP_LEG_PIN    = 4'h0;
    localparam logic [3:0]  FGP_LEG_SET    = 4'h4;
    localparam logic [3:0]  FGP_LEG_DIR    = 4'h8;
    localparam logic [3:0]  FGP_LEG_CLR    = 4'hC;

    localparam logic [31:0] FGP_RST_ZERO   = 32'h0000_0000;
    localparam logic [1:0]  FGP_RESP_OKAY  = 2'h0;
    localparam logic [1:0]  FGP_RESP_SLVERR = 2'h2;

    typedef enum logic [3:0] {
        FGP_F_DIR   = 4'h0,
        FGP_F_MASK  = 4'h1,
        FGP_F_PIN   = 4'h2,
        FGP_F_SET   = 4'h3,
        FGP_F_CLR   = 4'h4,
        FGP_F_OUT   = 4'h5,
        FGP_F_RISE  = 4'h6,
        FGP_F_FALL  = 4'h7,
        FGP_F_ESTAT = 4'h8,
        FGP_F_ECLR  = 4'h9,
        FGP_F_IST   = 4'hA,
        FGP_F_IMSK  = 4'hB
    } fgp_func_t;

    typedef struct packed {
        logic      ok;
        logic      port;
        logic      legacy;
        fgp_func_t fn;
    } fgp_dec_t;

    typedef struct packed {
        logic [8:0]  addr;
        logic [31:0] data;
        logic [3:0]  strb;
    } fgp_wreq_t;

endpackage : fgp_pkg

// [verif/fgp_pin_model.sv]
`timescale 1ns/10ps
module fgp_pin_model (
    // Design side.
    input  wire logic [1:0][31:0] pin_out,
    input  wire logic [1:0][31:0] pin_oe,
    // Board side.
    input  wire logic [1:0][31:0] board_val,
    output logic      [1:0][31:0] pin_in
);
    // The board only drives pins the port has released, so a driven pin reads back itself.
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & board_val);
endmodule : fgp_pin_model

// [verif/fast_parallel_io_port_tb_top.sv]
`timescale 1ns/10ps
module fast_parallel_io_port_tb_top;
    import fgp_pkg::*;
    logic             aclk, aresetn, run, awvalid, awready, wvalid, wready, bvalid, bready;
    logic             arvalid, arready, rvalid, rready, ext_irq, irq, shared, wake;
    logic [8:0]       awaddr, araddr;
    logic [31:0]      wdata, rdata, lfsr, exp, tmp;
    logic [3:0]       wstrb;
    logic [1:0]       bresp, rresp;
    logic [1:0][31:0] psel, pout, poe, pin_in, pin_out, pin_oe, board;
    logic [3:0]       stb [4] = '{4'h1, 4'h2, 4'hC, 4'hF};
    logic [33:0]      rq [$];
    logic [1:0]       bq [$];
    int               bad_count, num_checks;
    ////////////////////////////////////////////////////////////////////////////////
    fgp_port u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .periph_sel(psel), .periph_out(pout), .periph_oe(poe),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ext_irq_in(ext_irq),
        .irq(irq), .shared_external_irq_line(shared), .wake_req(wake));
    fgp_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .board_val(board),
        .pin_in(pin_in));
    ////////////////////////////////////////////////////////////////////////////////
    // The clock can be parked low to show that wake-up needs no clock.
    initial begin
        aclk = 1'b0;
        run = 1'b1;
        forever #4 aclk = run ? ~aclk : aclk;
    end
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] want);
        num_checks++;
        if (seen !== want) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, want, seen);
        end
    endtask : chk
    task automatic results;
        if (bad_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results
    task automatic wr(input logic [8:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] r);
        bq.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [8:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
    endtask : rd
    task automatic settle(input int n);
        repeat (n) @(posedge aclk);
        #1;
    endtask : settle
    // Read data and write responses are compared in the cycle they are handed over.
    always @(posedge aclk) begin
        if (rvalid && rready) chk("read", {rresp, rdata}, rq.pop_front());
        if (bvalid && bready) chk("bresp", {32'h0, bresp}, {32'h0, bq.pop_front()});
    end
    initial begin
        #300000;
        bad_count++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, ext_irq} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        {psel, pout, poe, board} = '0;
        lfsr = 32'h5747;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rd(9'h000, 32'h0, FGP_RESP_OKAY);
        chk("pin_oe", pin_oe[0] | pin_oe[1], 34'h0);
        wr(9'h000, 32'hFFFF_0000, 4'hF, FGP_RESP_OKAY);
        lfsr = nxt(lfsr);
        wr(9'h00C, lfsr, 4'hF, FGP_RESP_OKAY);
        tmp = nxt(lfsr);
        exp = lfsr & ~tmp;
        wr(9'h010, tmp, 4'hF, FGP_RESP_OKAY);
        rd(9'h014, exp, FGP_RESP_OKAY);
        rd(9'h00C, exp, FGP_RESP_OKAY);
        rd(9'h010, 32'h0, FGP_RESP_OKAY);
        chk("pin_oe", pin_oe[0], 32'hFFFF_0000);
        chk("pin_out", pin_out[0] & 32'hFFFF_0000, exp & 32'hFFFF_0000);
        lfsr = nxt(tmp);
        board[0] <= lfsr;
        settle(3);
        rd(9'h008, (exp & 32'hFFFF_0000) | (lfsr & 32'h0000_FFFF), FGP_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            wr(9'h008, lfsr, stb[i], FGP_RESP_OKAY);
            for (int b = 0; b < 4; b++) if (stb[i][b]) exp[8*b +: 8] = lfsr[8*b +: 8];
            rd(9'h014, exp, FGP_RESP_OKAY);
        end
        wr(9'h004, 32'h0000_FFFF, 4'hF, FGP_RESP_OKAY);
        lfsr = nxt(lfsr);
        wr(9'h008, lfsr, 4'hF, FGP_RESP_OKAY);
        exp = (exp & 32'h0000_FFFF) | (lfsr & 32'hFFFF_0000);
        settle(3);
        rd(9'h008, exp & 32'hFFFF_0000, FGP_RESP_OKAY);
        wr(9'h004, 32'h0, 4'hF, FGP_RESP_OKAY);
        psel[0] <= 32'h0000_00FF;
        pout[0] <= 32'h0000_00A5;
        poe[0] <= 32'h0000_000F;
        settle(1);
        chk("periph_out", pin_out[0][7:0], 8'hA5);
        chk("periph_oe", pin_oe[0][7:0], 8'h0F);
        psel[0] <= '0;
        wr(9'h104, 32'h0000_0003, 4'hF, FGP_RESP_OKAY);
        rd(9'h014, exp | 32'h3, FGP_RESP_OKAY);
        rd(9'h108, 32'hFFFF_0000, FGP_RESP_OKAY);
        wr(9'h10C, 32'h0000_0003, 4'hF, FGP_RESP_OKAY);
        rd(9'h014, exp & ~32'h3, FGP_RESP_OKAY);
        rd(9'h1FC, 32'h0, FGP_RESP_SLVERR);
        wr(9'h1FC, 32'hFFFF_FFFF, 4'hF, FGP_RESP_SLVERR);
        // Baseline first, so enabling detection cannot see a stale edge.
        board[0] <= '0;
        board[1] <= 32'h0000_0002;
        settle(4);
        wr(9'h0C4, 32'h0000_0003, 4'hF, FGP_RESP_OKAY);
        wr(9'h080, 32'h0000_0001, 4'hF, FGP_RESP_OKAY);
        wr(9'h094, 32'h0000_0006, 4'hF, FGP_RESP_OKAY);
        wr(9'h090, 32'h0000_0004, 4'hF, FGP_RESP_OKAY);
        board[0] <= 32'h0000_0001;
        board[1] <= 32'h0000_0004;
        settle(6);
        chk("irq", irq, 1'b1);
        chk("shared_line", shared, 1'b1);
        wr(9'h0C4, 32'h0, 4'hF, FGP_RESP_OKAY);
        chk("irq_masked", irq, 1'b0);
        ext_irq <= 1'b1;
        settle(1);
        chk("shared_ext", shared, 1'b1);
        ext_irq <= 1'b0;
        wr(9'h0C4, 32'h0000_0003, 4'hF, FGP_RESP_OKAY);
        rd(9'h088, 32'h0000_0001, FGP_RESP_OKAY);
        rd(9'h098, 32'h0000_0006, FGP_RESP_OKAY);
        rd(9'h0C0, 32'h0000_0003, FGP_RESP_OKAY);
        rd(9'h0C0, 32'h0, FGP_RESP_OKAY);
        chk("irq_clr", irq, 1'b0);
        rd(9'h088, 32'h0000_0001, FGP_RESP_OKAY);
        wr(9'h08C, 32'h0000_0001, 4'hF, FGP_RESP_OKAY);
        wr(9'h09C, 32'h0000_0006, 4'hF, FGP_RESP_OKAY);
        board[0] <= '0;
        board[1] <= '0;
        settle(6);
        rd(9'h088, 32'h0, FGP_RESP_OKAY);
        rd(9'h098, 32'h0000_0004, FGP_RESP_OKAY);
        // Clear the pending summary so wake-up can only come from the raw pin path.
        rd(9'h0C0, 32'h0000_0002, FGP_RESP_OKAY);
        settle(1);
        chk("wake_idle", wake, 1'b0);
        @(negedge aclk);
        run = 1'b0;
        board[0] = 32'h0000_0001;
        #20;
        chk("wake", wake, 1'b1);
        run = 1'b1;
        settle(6);
        rd(9'h088, 32'h0000_0001, FGP_RESP_OKAY);
        results();
    end
endmodule : fast_parallel_io_port_tb_top
